// ===== tcd_pkg.sv
// constants and types of the two-channel transfer request controller
// Contract
// - a request counts only when seen high on two consecutive samples
// - destination address steps by destination operand size when incrementing is on
// - each channel's active counter advances only on clocks it owns the bus
// - a preempted channel's active counter freezes until it owns the bus again
// - channel yields to a higher channel, a higher core level, or any external request
// - with the active count spent the channel releases the bus and idle counts every clock
// - misaligned source or destination address for its port size is a configuration error
// - zero byte count, or one not a multiple of the larger size, is an error
// - equal interrupt levels present channel 1 before channel 2
// - three clocks of recognition and arbitration precede the resulting bus cycle; steal mode takes four, as its request edge is registered first
// - a start with the request already high makes an internal request edge
// - the done line always ends the channel, internal request mode too
package tcd_pkg;
  localparam int NUM_CH = 2;
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_MASK = 8'h04;
  localparam logic [3:0] CH_PAGE_BASE = 4'h1;
  localparam logic [1:0] SEL_CCR = 2'h0;
  localparam logic [1:0] SEL_SAR = 2'h1;
  localparam logic [1:0] SEL_DAR = 2'h2;
  localparam logic [1:0] SEL_BTC = 2'h3;
  localparam logic [31:0] REG_RST = 32'h0;
  localparam logic [3:0] STATUS_RST = 4'h0;
  localparam int ST_DONE = 0;
  localparam int ST_ERR = 1;
  localparam int BUSY_BIT = 31;
  localparam int CNT_W = 8;
  localparam int ACTIVE_CYCLES = 16;
  localparam int IDLE_BASE = 16;
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_WORD = 2'h1;
  localparam logic [1:0] SZ_RSVD = 2'h3;
  typedef enum logic [1:0] {
    REQ_INTERNAL = 2'b00,
    REQ_BURST = 2'b01,
    REQ_STEAL = 2'b10,
    REQ_RSVD = 2'b11
  } tcd_req_mode_t;
  typedef enum logic [1:0] {
    OWN_CPU = 2'b00,
    OWN_CH1 = 2'b01,
    OWN_CH2 = 2'b10
  } tcd_owner_t;
  typedef struct packed {
    logic [10:0] rsvd;
    logic [2:0] int_level;
    logic [2:0] interrupt_service_mask;
    logic [2:0] master_arbitration_level;
    logic [1:0] bus_bandwidth_field;
    logic [1:0] dst_size;
    logic [1:0] src_size;
    logic src_increment;
    logic dest_addr_increment;
    logic single_address_enable;
    tcd_req_mode_t req_mode;
    logic start;
  } tcd_ccr_t;
  typedef struct packed {
    logic want;
    logic busy;
    logic done_p;
    logic err_p;
    logic [31:0] src;
    logic [31:0] dst;
    logic [31:0] byte_transfer_count;
  } tcd_chan_t;
endpackage

// ===== tcd_channel.sv
// one transfer channel: registers, request recognition, rate limiting
`timescale 1ns/100ps
`default_nettype none
module tcd_channel #(
  parameter int ACTIVE_CYCLES = tcd_pkg::ACTIVE_CYCLES,
  parameter int IDLE_BASE = tcd_pkg::IDLE_BASE
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [3:0] i_wr_sel,
  input wire logic [31:0] i_wdata,
  input wire logic i_req,
  input wire logic i_done,
  input wire logic i_own,
  input wire logic i_cycle_end,
  output var tcd_pkg::tcd_ccr_t o_ccr,
  output var tcd_pkg::tcd_chan_t o_st,
  output var logic o_ack
);
  function automatic logic [31:0] sz_bytes(input logic [1:0] c);
    sz_bytes = (c == tcd_pkg::SZ_BYTE) ? 32'h1 : (c == tcd_pkg::SZ_WORD) ? 32'h2 : 32'h4;
  endfunction

  tcd_pkg::tcd_ccr_t ccr_q;
  tcd_pkg::tcd_ccr_t new_ccr;
  logic [31:0] sar_q, dar_q, btc_q;
  logic busy_q, smp_q, rec_q, rec_prev_q, pend_q, idle_q, done_p_q, err_p_q, ack_q;
  logic [tcd_pkg::CNT_W-1:0] cnt_q;
  logic [31:0] nsrc, ndst, nbig, src_b, dst_b, big_b;
  logic bad, start_wr, go, stop_wr, xfer, last, term, req_edge, lim, act_out, demand, want;
  logic [tcd_pkg::CNT_W-1:0] idle_len;

  ////////////////////////////////////////////////////////////////////////////
  assign new_ccr = tcd_pkg::tcd_ccr_t'(i_wdata);
  assign nsrc = sz_bytes(new_ccr.src_size);
  assign ndst = sz_bytes(new_ccr.dst_size);
  assign nbig = (nsrc > ndst) ? nsrc : ndst;
  // checked against the sizes being written, so one write both sets up and starts
  assign bad = (|(sar_q & (nsrc - 32'h1))) | (|(dar_q & (ndst - 32'h1)))
    | (btc_q == 32'h0) | (|(btc_q & (nbig - 32'h1)))
    | (new_ccr.src_size == tcd_pkg::SZ_RSVD) | (new_ccr.dst_size == tcd_pkg::SZ_RSVD);
  assign start_wr = i_wr_sel[0] & new_ccr.start & !busy_q;
  assign go = start_wr & !bad;
  assign stop_wr = i_wr_sel[0] & !new_ccr.start;
  assign src_b = sz_bytes(ccr_q.src_size);
  assign dst_b = sz_bytes(ccr_q.dst_size);
  assign big_b = (src_b > dst_b) ? src_b : dst_b;
  assign xfer = busy_q & i_own & i_cycle_end;
  assign last = xfer & (btc_q <= big_b);
  assign term = busy_q & i_done;
  assign req_edge = rec_q & !rec_prev_q;
  assign lim = ccr_q.bus_bandwidth_field != 2'h0;
  assign idle_len = tcd_pkg::CNT_W'(IDLE_BASE) << (ccr_q.bus_bandwidth_field - 2'h1);
  assign act_out = lim & !idle_q & (cnt_q == tcd_pkg::CNT_W'(ACTIVE_CYCLES));
  // burst keeps asking while the request level stays recognised
  assign demand = (ccr_q.req_mode == tcd_pkg::REQ_INTERNAL) ? 1'b1 :
    (ccr_q.req_mode == tcd_pkg::REQ_BURST) ? rec_q :
    (ccr_q.req_mode == tcd_pkg::REQ_STEAL) ? pend_q : 1'b0;
  assign want = busy_q & !idle_q & !act_out & demand & !term;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      smp_q <= 1'b0;
      rec_q <= 1'b0;
      rec_prev_q <= 1'b0;
      pend_q <= 1'b0;
    end else begin
      smp_q <= i_req;
      rec_q <= i_req & smp_q;
      rec_prev_q <= go ? 1'b0 : rec_q;
      pend_q <= busy_q & (req_edge | (pend_q & !xfer));
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ccr_q <= tcd_pkg::tcd_ccr_t'(tcd_pkg::REG_RST);
      sar_q <= tcd_pkg::REG_RST;
      dar_q <= tcd_pkg::REG_RST;
      btc_q <= tcd_pkg::REG_RST;
    end else begin
      if (i_wr_sel[0]) begin
        ccr_q <= new_ccr;
      end
      if (i_wr_sel[1] & !busy_q) begin
        sar_q <= i_wdata;
      end else if (xfer & ccr_q.src_increment) begin
        sar_q <= sar_q + src_b;
      end
      if (i_wr_sel[2] & !busy_q) begin
        dar_q <= i_wdata;
      end else if (xfer & ccr_q.dest_addr_increment) begin
        dar_q <= dar_q + dst_b;
      end
      if (i_wr_sel[3] & !busy_q) begin
        btc_q <= i_wdata;
      end else if (xfer) begin
        btc_q <= last ? 32'h0 : btc_q - big_b;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      busy_q <= 1'b0;
      done_p_q <= 1'b0;
      err_p_q <= 1'b0;
      ack_q <= 1'b0;
    end else begin
      busy_q <= go | (busy_q & !(last | term | stop_wr));
      done_p_q <= last | term;
      err_p_q <= start_wr & bad;
      ack_q <= busy_q & (ccr_q.req_mode != tcd_pkg::REQ_INTERNAL) & i_own & !i_cycle_end;
    end
  end

  // the active count stalls while another master holds the bus
  always_ff @(posedge i_clk) begin
    if (i_rst | !busy_q | !lim) begin
      idle_q <= 1'b0;
      cnt_q <= '0;
    end else if (idle_q) begin
      if (cnt_q == idle_len - tcd_pkg::CNT_W'(1)) begin
        idle_q <= 1'b0;
        cnt_q <= '0;
      end else begin
        cnt_q <= cnt_q + tcd_pkg::CNT_W'(1);
      end
    end else if (act_out) begin
      if (!i_own) begin
        idle_q <= 1'b1;
        cnt_q <= '0;
      end
    end else if (i_own) begin
      cnt_q <= cnt_q + tcd_pkg::CNT_W'(1);
    end
  end

  assign o_ccr = ccr_q;
  assign o_st = '{want, busy_q, done_p_q, err_p_q, sar_q, dar_q, btc_q};
  assign o_ack = ack_q;

  ////////////////////////////////////////////////////////////////////////////
  a_req_recog: assert property (@(posedge i_clk) disable iff (i_rst)
    rec_q |-> $past(i_req, 1) && $past(i_req, 2))
    else $error("request recognised without two samples");
  a_burst_latency: assert property (@(posedge i_clk) disable iff (i_rst)
    (want && ccr_q.req_mode == tcd_pkg::REQ_BURST) |-> $past(smp_q, 1) && $past(i_req, 2))
    else $error("burst demand earlier than two clocks");
  a_dest_step: assert property (@(posedge i_clk) disable iff (i_rst)
    (xfer && ccr_q.dest_addr_increment && !i_wr_sel[2]) |=> dar_q == $past(dar_q) + $past(dst_b))
    else $error("destination did not step by destination size");
  a_active_count: assert property (@(posedge i_clk) disable iff (i_rst)
    (busy_q && lim && !idle_q && !act_out && i_own && !i_done && !stop_wr && !last)
    |=> cnt_q == $past(cnt_q) + tcd_pkg::CNT_W'(1))
    else $error("active count missed an owned clock");
  a_active_freeze: assert property (@(posedge i_clk) disable iff (i_rst)
    (busy_q && lim && !idle_q && !act_out && !i_own && !term && !stop_wr) |=> $stable(cnt_q))
    else $error("active count moved without the bus");
  a_idle_count: assert property (@(posedge i_clk) disable iff (i_rst)
    (busy_q && idle_q && cnt_q != idle_len - tcd_pkg::CNT_W'(1) && !term && !stop_wr)
    |=> idle_q && cnt_q == $past(cnt_q) + tcd_pkg::CNT_W'(1))
    else $error("idle count did not advance");
  a_idle_reload: assert property (@(posedge i_clk) disable iff (i_rst)
    (busy_q && idle_q && cnt_q == idle_len - tcd_pkg::CNT_W'(1) && !term && !stop_wr)
    |=> !idle_q && cnt_q == '0)
    else $error("active count not reloaded");
  a_cfg_error: assert property (@(posedge i_clk) disable iff (i_rst)
    (start_wr && |(sar_q & (nsrc - 32'h1))) |=> err_p_q && !busy_q)
    else $error("misaligned source accepted");
  a_done_stop: assert property (@(posedge i_clk) disable iff (i_rst)
    (busy_q && i_done) |=> !busy_q && done_p_q)
    else $error("done line did not end the channel");
  a_steal_edge: assert property (@(posedge i_clk) disable iff (i_rst)
    (go && rec_q && i_req && new_ccr.req_mode == tcd_pkg::REQ_STEAL) |=> ##1 pend_q || !busy_q)
    else $error("start with request high made no edge");
  c_idle_phase: cover property (@(posedge i_clk) disable iff (i_rst) idle_q ##1 !idle_q);
  c_steal_start: cover property (@(posedge i_clk) disable iff (i_rst) go && rec_q);
endmodule
`default_nettype wire

// ===== tcd_dma.sv
// two-channel transfer controller top: APB registers, bus arbitration, interrupts
//
// Implementation choices: the placing of the registers and register access over APB.
`timescale 1ns/100ps
`default_nettype none
module tcd_dma #(
  parameter int ACTIVE_CYCLES = tcd_pkg::ACTIVE_CYCLES,
  parameter int IDLE_BASE = tcd_pkg::IDLE_BASE
) (
  input wire logic I_MCLK,
  input wire logic I_RST,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output var logic [31:0] O_PRDATA,
  output var logic O_PREADY,
  output var logic O_PSLVERR,
  input wire logic [1:0] I_TRANSFER_REQUEST_IN,
  input wire logic [1:0] I_TRANSFER_DONE_LINE,
  output var logic [1:0] O_TRANSFER_ACKNOWLEDGE_OUT,
  input wire logic I_EXT_BUS_REQ,
  input wire logic [2:0] I_CORE_MASK_LEVEL,
  input wire logic [2:0] I_CORE_IRQ_LEVEL,
  input wire logic I_BUS_CYCLE_DONE,
  output var logic O_DMA_CYCLE,
  output var logic [1:0] O_DMA_CHANNEL,
  output var logic [31:0] O_DMA_SRC_ADDR,
  output var logic [31:0] O_DMA_DST_ADDR,
  output var logic O_IRQ,
  output var logic [2:0] O_IRQ_LEVEL,
  output var logic O_IRQ_CHANNEL
);
  tcd_pkg::tcd_ccr_t channel_control_reg [tcd_pkg::NUM_CH];
  tcd_pkg::tcd_chan_t st [tcd_pkg::NUM_CH];
  logic [31:0] chrd [tcd_pkg::NUM_CH];
  logic [3:0] wr_sel [tcd_pkg::NUM_CH];
  logic [1:0] want, allow, win, own, cyc_end, hit_ch, ack;
  tcd_pkg::tcd_owner_t owner_q, owner_d;
  logic [1:0] owner_bits;
  logic [2:0] core_lvl;
  logic pready_q, pslverr_q, cyc_q, irq_q, irq_ch_q;
  logic [31:0] prdata_q, src_q, dst_q, rdata;
  logic [2:0] irq_lvl_q;
  logic [3:0] status_q, mask_q, status_d, mask_d, events, clr, pend;
  logic acc, setup_acc, fire, hit_stat, hit_mask, mapped, wr;
  logic [3:0] page;
  logic [1:0] sel;
  logic act0, act1, pick0;

  ////////////////////////////////////////////////////////////////////////////
  // apb decode; one wait state, so read data and writes line up with pready
  assign acc = I_PSEL & I_PENABLE;
  assign setup_acc = acc & !pready_q;
  assign fire = acc & pready_q;
  assign page = I_PADDR[7:4];
  assign sel = I_PADDR[3:2];
  assign hit_stat = I_PADDR == tcd_pkg::ADDR_STATUS;
  assign hit_mask = I_PADDR == tcd_pkg::ADDR_MASK;
  assign mapped = hit_stat | hit_mask | (|hit_ch);
  assign wr = fire & I_PWRITE & mapped;

  genvar ch;
  generate
    for (ch = 0; ch < tcd_pkg::NUM_CH; ch++) begin : g_ch
      assign hit_ch[ch] = (I_PADDR[1:0] == 2'h0) & (page == tcd_pkg::CH_PAGE_BASE + 4'(ch));
      assign wr_sel[ch] = {4{wr & hit_ch[ch]}} & (4'h1 << sel);
      assign chrd[ch] = (sel == tcd_pkg::SEL_CCR) ?
          {st[ch].busy, channel_control_reg[ch][tcd_pkg::BUSY_BIT-1:0]} :
        (sel == tcd_pkg::SEL_SAR) ? st[ch].src :
        (sel == tcd_pkg::SEL_DAR) ? st[ch].dst : st[ch].byte_transfer_count;
      assign want[ch] = st[ch].want;
      // core outranks a channel when its mask or pending level exceeds the channel's mask
      assign allow[ch] = !I_EXT_BUS_REQ & (core_lvl <= channel_control_reg[ch].interrupt_service_mask);
      assign own[ch] = owner_bits[ch];
      assign cyc_end[ch] = owner_bits[ch] & I_BUS_CYCLE_DONE;
      tcd_channel #(
        .ACTIVE_CYCLES(ACTIVE_CYCLES),
        .IDLE_BASE(IDLE_BASE)
      ) u_chan (
        .i_clk(I_MCLK),
        .i_rst(I_RST),
        .i_wr_sel(wr_sel[ch]),
        .i_wdata(I_PWDATA),
        .i_req(I_TRANSFER_REQUEST_IN[ch]),
        .i_done(I_TRANSFER_DONE_LINE[ch]),
        .i_own(own[ch]),
        .i_cycle_end(cyc_end[ch]),
        .o_ccr(channel_control_reg[ch]),
        .o_st(st[ch]),
        .o_ack(ack[ch])
      );
    end
  endgenerate

  assign rdata = hit_stat ? {28'h0, status_q} : hit_mask ? {28'h0, mask_q} :
    hit_ch[0] ? chrd[0] : hit_ch[1] ? chrd[1] : 32'h0;

  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= tcd_pkg::REG_RST;
    end else begin
      pready_q <= setup_acc;
      pslverr_q <= setup_acc & !mapped;
      prdata_q <= (setup_acc & !I_PWRITE) ? rdata : 32'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // arbitration between cycles only: a started cycle is never split
  assign core_lvl = (I_CORE_MASK_LEVEL > I_CORE_IRQ_LEVEL) ? I_CORE_MASK_LEVEL : I_CORE_IRQ_LEVEL;
  assign owner_bits = owner_q;
  assign win[0] = want[0] & allow[0] & !(want[1] & allow[1] &
    (channel_control_reg[1].master_arbitration_level > channel_control_reg[0].master_arbitration_level));
  assign win[1] = want[1] & allow[1] & !(want[0] & allow[0] &
    (channel_control_reg[0].master_arbitration_level >= channel_control_reg[1].master_arbitration_level));

  always_comb begin
    owner_d = owner_q;
    case (owner_q)
      tcd_pkg::OWN_CPU: begin
        if (win[0]) begin
          owner_d = tcd_pkg::OWN_CH1;
        end else if (win[1]) begin
          owner_d = tcd_pkg::OWN_CH2;
        end
      end
      tcd_pkg::OWN_CH1, tcd_pkg::OWN_CH2: begin
        if (I_BUS_CYCLE_DONE) begin
          owner_d = tcd_pkg::OWN_CPU;
        end
      end
      default: owner_d = tcd_pkg::OWN_CPU;
    endcase
  end

  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      owner_q <= tcd_pkg::OWN_CPU;
      cyc_q <= 1'b0;
      src_q <= tcd_pkg::REG_RST;
      dst_q <= tcd_pkg::REG_RST;
    end else begin
      owner_q <= owner_d;
      cyc_q <= owner_d != tcd_pkg::OWN_CPU;
      if (owner_q == tcd_pkg::OWN_CPU && owner_d == tcd_pkg::OWN_CH1) begin
        src_q <= st[0].src;
        dst_q <= st[0].dst;
      end else if (owner_q == tcd_pkg::OWN_CPU && owner_d == tcd_pkg::OWN_CH2) begin
        src_q <= st[1].src;
        dst_q <= st[1].dst;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sticky events, write one to clear; a new event in the clearing cycle survives
  assign events = {st[1].err_p, st[1].done_p, st[0].err_p, st[0].done_p};
  assign clr = (wr & hit_stat) ? I_PWDATA[3:0] : 4'h0;
  assign status_d = events | (status_q & ~clr);
  assign mask_d = (wr & hit_mask) ? I_PWDATA[3:0] : mask_q;
  assign pend = status_d & mask_d;
  assign act0 = |pend[1:0];
  assign act1 = |pend[3:2];
  assign pick0 = act0 & (!act1 | (channel_control_reg[0].int_level >= channel_control_reg[1].int_level));

  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      status_q <= tcd_pkg::STATUS_RST;
      mask_q <= tcd_pkg::STATUS_RST;
      irq_q <= 1'b0;
      irq_ch_q <= 1'b0;
      irq_lvl_q <= 3'h0;
    end else begin
      status_q <= status_d;
      mask_q <= mask_d;
      irq_q <= act0 | act1;
      irq_ch_q <= !pick0 & act1;
      irq_lvl_q <= pick0 ? channel_control_reg[0].int_level : act1 ? channel_control_reg[1].int_level : 3'h0;
    end
  end

  assign O_PRDATA = prdata_q;
  assign O_PREADY = pready_q;
  assign O_PSLVERR = pslverr_q;
  assign O_TRANSFER_ACKNOWLEDGE_OUT = ack;
  assign O_DMA_CYCLE = cyc_q;
  assign O_DMA_CHANNEL = owner_bits;
  assign O_DMA_SRC_ADDR = src_q;
  assign O_DMA_DST_ADDR = dst_q;
  assign O_IRQ = irq_q;
  assign O_IRQ_LEVEL = irq_lvl_q;
  assign O_IRQ_CHANNEL = irq_ch_q;

  ////////////////////////////////////////////////////////////////////////////
  a_ext_yield: assert property (@(posedge I_MCLK) disable iff (I_RST)
    (owner_q == tcd_pkg::OWN_CPU && I_EXT_BUS_REQ) |=> owner_q == tcd_pkg::OWN_CPU)
    else $error("channel took bus under external request");
  a_core_yield: assert property (@(posedge I_MCLK) disable iff (I_RST)
    (owner_q == tcd_pkg::OWN_CPU && core_lvl > channel_control_reg[0].interrupt_service_mask)
    |=> owner_q != tcd_pkg::OWN_CH1)
    else $error("channel 1 took bus over higher core level");
  a_level_yield: assert property (@(posedge I_MCLK) disable iff (I_RST)
    (owner_q == tcd_pkg::OWN_CPU && want == 2'b11 && allow == 2'b11 &&
     channel_control_reg[1].master_arbitration_level > channel_control_reg[0].master_arbitration_level)
    |=> owner_q == tcd_pkg::OWN_CH2)
    else $error("higher arbitration level lost");
  a_grant_next: assert property (@(posedge I_MCLK) disable iff (I_RST)
    (owner_q == tcd_pkg::OWN_CPU && win[0]) |=> owner_q == tcd_pkg::OWN_CH1 && O_DMA_CYCLE)
    else $error("grant not one clock after demand");
  a_cycle_whole: assert property (@(posedge I_MCLK) disable iff (I_RST)
    (owner_q != tcd_pkg::OWN_CPU && !I_BUS_CYCLE_DONE) |=> $stable(owner_q))
    else $error("bus cycle split");
  a_irq_tie: assert property (@(posedge I_MCLK) disable iff (I_RST)
    (|pend[1:0] && |pend[3:2] && channel_control_reg[0].int_level == channel_control_reg[1].int_level)
    |=> O_IRQ && !O_IRQ_CHANNEL)
    else $error("channel 2 presented over channel 1 at equal level");
  a_sticky_set: assert property (@(posedge I_MCLK) disable iff (I_RST)
    (events[0] && clr[0]) |=> status_q[0])
    else $error("event lost in clearing cycle");
  c_burst_pair: cover property (@(posedge I_MCLK) disable iff (I_RST)
    owner_q == tcd_pkg::OWN_CH1 ##1 owner_q == tcd_pkg::OWN_CPU ##1 owner_q == tcd_pkg::OWN_CH1);
  c_cfg_err: cover property (@(posedge I_MCLK) disable iff (I_RST) st[0].err_p);
  c_irq_ch2: cover property (@(posedge I_MCLK) disable iff (I_RST) O_IRQ && O_IRQ_CHANNEL);
endmodule
`default_nettype wire

// ===== tcd_periph.sv
// far-side peripheral model that raises and drops transfer requests
`timescale 1ns/100ps
`default_nettype none
module tcd_periph (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [1:0] i_want,
  output logic [1:0] o_req
);
  logic [1:0] held_q;
  // a raised request stays up two samples at least, so a short want still counts
  // dropping as soon as want falls keeps bursts from running one transfer long
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_req <= 2'h0;
      held_q <= 2'h0;
    end else begin
      o_req <= i_want | (o_req & ~held_q);
      held_q <= o_req;
    end
  end
endmodule
`default_nettype wire

// ===== tb_tcd_dma.sv
// self-checking bench of the two-channel transfer controller
`timescale 1ns/100ps
`default_nettype none
module tb_tcd_dma;
  logic clk, rst, psel, pen, pwr, ext, bdone, pready, pslverr, dcyc, irq, irqch;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rnd, base, sa, da;
  logic [1:0] want, req, done_l, ack, dch;
  logic [2:0] irql, cml;
  int k;
  logic [32:0] expq[$];
  int num_errors = 0;
  int n_checks = 0;
  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end
  // short rate-limit counts keep the run brief
  tcd_dma #(.ACTIVE_CYCLES(4), .IDLE_BASE(4)) tcd_dma_inst (.I_MCLK(clk), .I_RST(rst),
    .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata),
    .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr), .I_TRANSFER_REQUEST_IN(req),
    .I_TRANSFER_DONE_LINE(done_l), .O_TRANSFER_ACKNOWLEDGE_OUT(ack), .I_EXT_BUS_REQ(ext),
    .I_CORE_MASK_LEVEL(cml), .I_CORE_IRQ_LEVEL(cml), .I_BUS_CYCLE_DONE(bdone),
    .O_DMA_CYCLE(dcyc), .O_DMA_CHANNEL(dch), .O_DMA_SRC_ADDR(sa), .O_DMA_DST_ADDR(da),
    .O_IRQ(irq), .O_IRQ_LEVEL(irql), .O_IRQ_CHANNEL(irqch));
  tcd_periph tcd_periph_inst (.i_clk(clk), .i_rst(rst), .i_want(want), .o_req(req));
  ////////////////////////////////////////////////////////////////////////////////
  // every bus cycle lasts two clocks
  always @(posedge clk) bdone <= dcyc && !bdone && !rst;
  always @(posedge clk) if (pready === 1'b1 && pwr === 1'b0) begin
    if (expq.size() == 0) chk(33'h0, 33'h1);
    else chk({pslverr, prdata}, expq.pop_front());
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [32:0] e);
    int n;
    if (!w) expq.push_back(e);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) chk(33'h0, 33'h1);
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, {1'b0, e});
  endtask
  task automatic wait_irq(input logic lvl);
    int n;
    n = 0;
    while (irq !== lvl && n < 400) begin
      @(posedge clk);
      n++;
    end
    chk({32'h0, irq}, {32'h0, lvl});
  endtask
  task automatic setup(input logic [7:0] pg, input logic [31:0] s, input logic [31:0] d,
                       input logic [31:0] c);
    wr(pg + 8'h4, s);
    wr(pg + 8'h8, d);
    wr(pg + 8'hc, c);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    tally_and_finish();
  end
  initial begin
    {psel, pen, pwr, ext, paddr, pwdata, want, done_l, cml} = '0;
    rst = 1'b1;
    rnd = lfsr(32'hff75);
    base = rnd & 32'hfff0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(8'h00, 32'h0);
    rd(8'h14, 32'h0);
    apb(1'b0, 8'h40, 32'h0, {1'b1, 32'h0});
    wr(8'h04, 32'hf);
    $display("test reset_map done");
    // single address enable stays zero in every control word below
    setup(8'h10, base, base, 32'h0);
    wr(8'h10, 32'h38141);
    wait_irq(1'b1);
    rd(8'h00, 32'h2);
    wr(8'h00, 32'h2);
    wait_irq(1'b0);
    setup(8'h10, base + 32'h1, base, 32'h4);
    wr(8'h10, 32'h38141);
    wait_irq(1'b1);
    rd(8'h00, 32'h2);
    wr(8'h00, 32'h2);
    wait_irq(1'b0);
    $display("test config_error done");
    setup(8'h10, base, base + 32'h100, 32'h4);
    want <= 2'h1;
    wr(8'h10, 32'h38133);
    wait_irq(1'b1);
    want <= 2'h0;
    rd(8'h00, 32'h1);
    rd(8'h18, base + 32'h104);
    rd(8'h1c, 32'h0);
    wr(8'h00, 32'h1);
    $display("test burst done");
    want <= 2'h2;
    setup(8'h20, base, base, 32'h1);
    wr(8'h20, 32'h38005);
    wait_irq(1'b1);
    chk({32'h0, irqch}, 33'h1);
    want <= 2'h0;
    rd(8'h00, 32'h4);
    wr(8'h00, 32'h4);
    $display("test steal_preasserted done");
    setup(8'h10, base, base, 32'h100);
    wr(8'h10, 32'h38031);
    ext <= 1'b1;
    repeat (4) @(posedge clk);
    chk({32'h0, dcyc}, 33'h0);
    ext <= 1'b0;
    done_l <= 2'h1;
    @(posedge clk);
    done_l <= 2'h0;
    wait_irq(1'b1);
    rd(8'h00, 32'h1);
    $display("test done_line done");
    wr(8'h00, 32'h1);
    wait_irq(1'b0);
    // limited rate with service mask 3; a core level of 4 holds the channel off
    setup(8'h10, base, base + 32'h200, 32'h20);
    cml <= 3'h4;
    wr(8'h10, 32'h18431);
    repeat (4) @(posedge clk);
    chk({32'h0, dcyc}, 33'h0);
    cml <= 3'h0;
    k = 0;
    while (dcyc !== 1'b1 && k < 20) begin
      @(posedge clk);
      k++;
    end
    chk({31'h0, dch}, {31'h0, 2'h1});
    chk({1'b0, sa}, {1'b0, base});
    chk({1'b0, da}, {1'b0, base + 32'h200});
    wait_irq(1'b1);
    rd(8'h00, 32'h1);
    rd(8'h18, base + 32'h220);
    $display("test rate_core done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
